// File: tfs_pkg.sv
// How it works
// - Three channel thermal monitors each report a warning level and a higher shutdown level.
// - Any monitor above the warning level sets the thermal warning flag while the outputs stay on.
// - The warning flag sits in diagnostic bit 0 and stays set after the die cools down.
// - The warning flag clears only on a command with the status reset request bit 0 set, once no warning remains.
// - Any monitor reaching the shutdown level latches every driver of all three half-bridges off.
// - The shutdown latch releases only when cooled below shutdown minus hysteresis, on a turn-on command with reset request.
// - A chip select fall with data in low shows the warning state on data out at once, before any clock edge.
// - That early data out level is low with no warning and high with the warning threshold exceeded.
// - The early level follows the sticky warning flag when chip select falls, so it stays high after the die cools until cleared.
// - The serial clock may rest at either level; its edges shift the remaining diagnostic bits out.
// - The first 16 bits out after chip select falls are the diagnostic status word.
// - Bits received on data in pass on through data out after 16 bits, for daisy chains.
// - Serial data is taken only while chip select is low; activity while deselected is ignored.
package tfs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Serial word layout
    localparam int          WORD_W       = 16;
    localparam int          NUM_CH       = 3;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          CLEAR_POS    = 0;
    localparam int          WARN_POS     = 0;
    localparam logic [15:0] TURN_ON_MASK = 16'h1FFE;
    localparam logic [15:0] CMD_RESET    = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CORE_PERIOD_NS = 5;
    localparam int          SYNC_STAGES    = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Frame handling states
    typedef enum logic [1:0] {
        TFS_IDLE  = 2'b00,
        TFS_DRAIN = 2'b01,
        TFS_APPLY = 2'b10
    } tfs_state_t;

endpackage : tfs_pkg

// File: tfs_fifo.sv
module tfs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Power of two depth keeps pointer wrap free
    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("tfs_fifo: DEPTH must be a power of two");
    end

    assign o_in_ready  = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // Storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + AW'(1);
            if (pop) rd_ptr <= rd_ptr + AW'(1);
            if (push && !pop) count <= count + (AW+1)'(1);
            else if (pop && !push) count <= count - (AW+1)'(1);
        end
    end

endmodule : tfs_fifo

// File: tfs_link.sv
module tfs_link #(
    parameter int W = 16
) (
    // Link clock and resets
    input  wire logic         i_sclk,
    input  wire logic         i_cs_n,
    input  wire logic         i_reset,
    // Serial data
    input  wire logic         i_si,
    // Status snapshot, frozen by the core during a frame
    input  wire logic [W-1:0] i_status,
    // Toward the core domain
    output logic              o_so_bit,
    output logic              o_shifted,
    output logic              o_start_tg,
    output logic              o_done_tg,
    output logic [W-1:0]      o_word
);
    localparam int CW = $clog2(W);

    logic          clr;
    logic [CW-1:0] cnt;
    logic          past;
    logic [W-1:0]  rx;

    initial begin
        if (W < 2 || (W & (W - 1)) != 0) $error("tfs_link: W must be a power of two");
    end

    // Deselect holds the shifter cleared, so bus activity is ignored
    assign clr = i_cs_n | i_reset;

    // Receive on rising clock, least significant bit first
    always_ff @(posedge i_sclk or posedge clr) begin
        if (clr) begin
            cnt  <= '0;
            past <= 1'b0;
            rx   <= '0;
        end else begin
            rx  <= {i_si, rx[W-1:1]};
            cnt <= cnt + CW'(1);
            if (cnt == CW'(W - 1)) past <= 1'b1;
        end
    end

    // Word and start events; not cleared by deselect, so no false toggle
    always_ff @(posedge i_sclk or posedge i_reset) begin
        if (i_reset) begin
            o_start_tg <= 1'b0;
            o_done_tg  <= 1'b0;
            o_word     <= '0;
        end else if (!i_cs_n) begin
            if (cnt == '0) o_start_tg <= ~o_start_tg;
            if (cnt == CW'(W - 1)) begin
                o_done_tg <= ~o_done_tg;
                o_word    <= {i_si, rx[W-1:1]};
            end
        end
    end

    // Transmit on falling clock: status first, then the delayed input
    always_ff @(negedge i_sclk or posedge clr) begin
        if (clr) begin
            o_so_bit  <= 1'b0;
            o_shifted <= 1'b0;
        end else begin
            o_shifted <= 1'b1;
            o_so_bit  <= past ? rx[0] : i_status[cnt];
        end
    end

endmodule : tfs_link

// File: tfs_top.sv
module tfs_top #(
    parameter int WORD_W     = tfs_pkg::WORD_W,
    parameter int NUM_CH     = tfs_pkg::NUM_CH,
    parameter int FIFO_DEPTH = tfs_pkg::FIFO_DEPTH
) (
    // Core clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_reset,
    // Serial link pins
    input  wire logic              i_sclk,
    input  wire logic              i_chip_select_n,
    input  wire logic              i_si,
    output logic                   o_so,
    // Thermal comparators, one per half-bridge
    input  wire logic [NUM_CH-1:0] i_warn_hot,
    input  wire logic [NUM_CH-1:0] i_shut_hot,
    input  wire logic [NUM_CH-1:0] i_shut_cool,
    // Other diagnostic bits from the protection logic
    input  wire logic [WORD_W-1:1] i_diag_other,
    // Control results
    output logic                   o_thermal_warn_flag,
    output logic                   o_all_off,
    output logic [WORD_W-1:0]      o_cmd_word,
    output logic [WORD_W-1:0]      o_drive_word,
    output logic                   o_cmd_valid,
    output logic                   o_frame_error
);
    localparam int WC = $clog2(FIFO_DEPTH) + 1;

    // Elaboration checks
    initial begin
        if (WORD_W != 16) $error("tfs_top: the serial word is 16 bits");
        if (NUM_CH < 1) $error("tfs_top: at least one thermal channel");
        if (FIFO_DEPTH < 2) $error("tfs_top: FIFO too shallow");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Synchronisers
    logic              cs_s1;
    logic              cs_s2;
    logic              cs_s3;
    logic              shift_s1;
    logic              shift_s2;
    logic              so_s1;
    logic              so_s2;
    logic              start_s1;
    logic              start_s2;
    logic              start_s3;
    logic              done_s1;
    logic              done_s2;
    logic              done_s3;
    logic [NUM_CH-1:0] warn_s1;
    logic [NUM_CH-1:0] warn_s2;
    logic [NUM_CH-1:0] shut_s1;
    logic [NUM_CH-1:0] shut_s2;
    logic [NUM_CH-1:0] cool_s1;
    logic [NUM_CH-1:0] cool_s2;

    // Link signals
    logic              link_so;
    logic              link_shifted;
    logic              link_start_tg;
    logic              link_done_tg;
    logic [WORD_W-1:0] link_word;
    logic [WORD_W-1:0] status_snap;

    // Frame bookkeeping
    logic              cs_rise;
    logic              word_done;
    logic              word_start;
    logic              partial;
    logic              overrun;
    logic [WC-1:0]     pushed;
    logic [WC-1:0]     frame_words;
    logic [WC-1:0]     popped;
    logic              frame_ok;
    logic [WORD_W-1:0] last_word;
    tfs_pkg::tfs_state_t state;
    tfs_pkg::tfs_state_t next_state;

    // FIFO
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic              fifo_out_ready;

    // Thermal state
    logic              any_warn;
    logic              any_shut;
    logic              all_cool;
    logic              apply;
    logic              clear_req;
    logic              turn_on;
    logic              next_warn;
    logic              next_off;
    logic              warn_flag;
    logic              all_off;

    ////////////////////////////////////////////////////////////////////////////
    // Link side shifter, clocked by the serial clock

    tfs_link #(
        .W (WORD_W)
    ) u_link (
        .i_sclk     (i_sclk),
        .i_cs_n     (i_chip_select_n),
        .i_reset    (i_reset),
        .i_si       (i_si),
        .i_status   (status_snap),
        .o_so_bit   (link_so),
        .o_shifted  (link_shifted),
        .o_start_tg (link_start_tg),
        .o_done_tg  (link_done_tg),
        .o_word     (link_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Crossings into the core clock

    // Chip select level, plus one stage for edge detection
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else begin
            cs_s1 <= i_chip_select_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end

    // Transmit bit and shift state from the link
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            shift_s1 <= 1'b0;
            shift_s2 <= 1'b0;
            so_s1    <= 1'b0;
            so_s2    <= 1'b0;
        end else begin
            shift_s1 <= link_shifted;
            shift_s2 <= shift_s1;
            so_s1    <= link_so;
            so_s2    <= so_s1;
        end
    end

    // Word and start toggles; a change is one event
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            start_s1 <= 1'b0;
            start_s2 <= 1'b0;
            start_s3 <= 1'b0;
            done_s1  <= 1'b0;
            done_s2  <= 1'b0;
            done_s3  <= 1'b0;
        end else begin
            start_s1 <= link_start_tg;
            start_s2 <= start_s1;
            start_s3 <= start_s2;
            done_s1  <= link_done_tg;
            done_s2  <= done_s1;
            done_s3  <= done_s2;
        end
    end

    // Thermal comparator levels come from analog, so they are synchronised
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            warn_s1 <= '0;
            warn_s2 <= '0;
            shut_s1 <= '0;
            shut_s2 <= '0;
            cool_s1 <= '1;
            cool_s2 <= '1;
        end else begin
            warn_s1 <= i_warn_hot;
            warn_s2 <= warn_s1;
            shut_s1 <= i_shut_hot;
            shut_s2 <= shut_s1;
            cool_s1 <= i_shut_cool;
            cool_s2 <= cool_s1;
        end
    end

    assign cs_rise    = cs_s2 & ~cs_s3;
    assign word_done  = done_s2 ^ done_s3;
    assign word_start = start_s2 ^ start_s3;

    ////////////////////////////////////////////////////////////////////////////
    // Diagnostic snapshot, frozen while selected so the link reads it stably

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            status_snap <= tfs_pkg::CMD_RESET;
        end else if (cs_s2) begin
            status_snap <= {i_diag_other, next_warn};
        end
    end

    // Data out: warning level while idle, so a chip select fall shows it at once
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_so <= 1'b0;
        end else if (cs_s2 || !shift_s2) begin
            o_so <= next_warn;
        end else begin
            o_so <= so_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received words collect in the FIFO until the frame ends

    tfs_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_core_clk),
        .i_reset     (i_reset),
        .i_in_valid  (word_done),
        .i_in_data   (link_word),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_out_valid),
        .o_out_data  (fifo_out_data),
        .i_out_ready (fifo_out_ready)
    );

    // Drained only between frames; a full FIFO drops the word and spoils the frame
    assign fifo_out_ready = (state == tfs_pkg::TFS_DRAIN) && (popped != frame_words);

    // Frame counters; a new word start wins over a word end in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            partial <= 1'b0;
            overrun <= 1'b0;
            pushed  <= '0;
        end else if (cs_rise) begin
            partial <= 1'b0;
            overrun <= 1'b0;
            pushed  <= '0;
        end else begin
            if (word_start) partial <= 1'b1;
            else if (word_done) partial <= 1'b0;
            if (word_done && !fifo_in_ready) overrun <= 1'b1;
            if (word_done && fifo_in_ready) pushed <= pushed + WC'(1);
        end
    end

    // Frame verdict taken at deselect
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            frame_ok    <= 1'b0;
            frame_words <= '0;
        end else if (cs_rise) begin
            frame_ok    <= !partial && !word_start && !overrun && (pushed != '0);
            frame_words <= pushed;
        end
    end

    // Frame state
    always_ff @(posedge i_core_clk) begin
        if (i_reset) state <= tfs_pkg::TFS_IDLE;
        else state <= next_state;
    end

    always_comb begin
        next_state = state;
        case (state)
            tfs_pkg::TFS_IDLE: begin
                if (cs_rise) next_state = tfs_pkg::TFS_DRAIN;
            end
            tfs_pkg::TFS_DRAIN: begin
                if (popped == frame_words) next_state = tfs_pkg::TFS_APPLY;
            end
            tfs_pkg::TFS_APPLY: begin
                next_state = tfs_pkg::TFS_IDLE;
            end
            default: begin
                next_state = tfs_pkg::TFS_IDLE;
            end
        endcase
    end

    // Drain keeps only the last word: in a chain it is this device's command
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            popped    <= '0;
            last_word <= tfs_pkg::CMD_RESET;
        end else if (state == tfs_pkg::TFS_IDLE) begin
            popped <= '0;
        end else if (fifo_out_ready && fifo_out_valid) begin
            popped    <= popped + WC'(1);
            last_word <= fifo_out_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command decode

    assign apply     = (state == tfs_pkg::TFS_APPLY) && frame_ok;
    assign clear_req = last_word[tfs_pkg::CLEAR_POS];
    assign turn_on   = |(last_word & tfs_pkg::TURN_ON_MASK);

    // Applied command and result pulses
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_cmd_word    <= tfs_pkg::CMD_RESET;
            o_cmd_valid   <= 1'b0;
            o_frame_error <= 1'b0;
        end else begin
            o_cmd_valid   <= apply;
            o_frame_error <= (state == tfs_pkg::TFS_APPLY) && !frame_ok;
            if (apply) o_cmd_word <= last_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Thermal protection

    assign any_warn = |warn_s2;
    assign any_shut = |shut_s2;
    assign all_cool = (&cool_s2) & ~any_shut;

    // Sticky warning; a live warning blocks the clear, so set wins
    assign next_warn = any_warn | (warn_flag & ~(apply & clear_req));

    // Shutdown latch; release needs cool, reset request and turn-on together
    assign next_off = any_shut | (all_off & ~(apply & clear_req & turn_on & all_cool));

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            warn_flag <= 1'b0;
            all_off   <= 1'b0;
        end else begin
            warn_flag <= next_warn;
            all_off   <= next_off;
        end
    end

    // Outputs; a warning alone leaves the drivers as commanded
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_thermal_warn_flag <= 1'b0;
            o_all_off           <= 1'b0;
            o_drive_word        <= tfs_pkg::CMD_RESET;
        end else begin
            o_thermal_warn_flag <= next_warn;
            o_all_off           <= next_off;
            if (next_off) o_drive_word <= tfs_pkg::CMD_RESET;
            else if (apply) o_drive_word <= last_word & tfs_pkg::TURN_ON_MASK;
        end
    end

endmodule : tfs_top

// File: tfs_checker.sv
module tfs_checker #(
    parameter int WORD_W = 16,
    parameter int NUM_CH = 3
) (
    // Core clock and reset
    input wire logic              i_core_clk,
    input wire logic              i_reset,
    // Link and thermal inputs
    input wire logic              i_chip_select_n,
    input wire logic              o_so,
    input wire logic [NUM_CH-1:0] i_warn_hot,
    input wire logic [NUM_CH-1:0] i_shut_hot,
    // Control results
    input wire logic              o_thermal_warn_flag,
    input wire logic              o_all_off,
    input wire logic [WORD_W-1:0] o_cmd_word,
    input wire logic [WORD_W-1:0] o_drive_word,
    input wire logic              o_cmd_valid,
    input wire logic              o_frame_error
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////
    // Accepted command asking for a status reset
    sequence s_clear_cmd;
        o_cmd_valid && o_cmd_word[tfs_pkg::CLEAR_POS];
    endsequence
    // Deselected long enough for the synchronisers to settle
    sequence s_idle_settled;
        (i_chip_select_n && $stable(o_thermal_warn_flag)) [*8];
    endsequence

    ////////////////////////////////////////////////////////////
    // Flags follow the comparators within the sync latency
    warn_rise_a: assert property ($rose(|i_warn_hot) |-> ##[1:4] o_thermal_warn_flag)
        else $error("warning flag not raised");
    shut_rise_a: assert property ($rose(|i_shut_hot) |-> ##[1:4] o_all_off)
        else $error("shutdown not latched");
    // Sticky flags drop only on an accepted request
    warn_clear_a: assert property ($fell(o_thermal_warn_flag) |-> s_clear_cmd)
        else $error("warning flag dropped without request");
    off_release_a: assert property ($fell(o_all_off) |-> s_clear_cmd ##0 (|(o_cmd_word & tfs_pkg::TURN_ON_MASK)))
        else $error("shutdown released without turn-on request");
    off_drive_a: assert property (o_all_off && $past(o_all_off) |-> o_drive_word == '0)
        else $error("drivers on during shutdown");
    drive_mask_a: assert property (o_cmd_valid && !o_all_off |-> o_drive_word == (o_cmd_word & tfs_pkg::TURN_ON_MASK))
        else $error("drive word not the masked command");
    // Command state moves only with an accepted frame
    cmd_only_a: assert property ($changed(o_cmd_word) |-> o_cmd_valid)
        else $error("command word changed without accept");
    err_no_cmd_a: assert property (o_frame_error |-> !o_cmd_valid)
        else $error("rejected frame applied");
    // Data out shows the warning level while idle
    early_so_a: assert property (s_idle_settled |-> o_so == o_thermal_warn_flag)
        else $error("idle data out differs from warning flag");
endmodule : tfs_checker

bind tfs_top tfs_checker #(.WORD_W(WORD_W), .NUM_CH(NUM_CH)) u_tfs_checker (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_chip_select_n(i_chip_select_n),
    .o_so(o_so), .i_warn_hot(i_warn_hot), .i_shut_hot(i_shut_hot),
    .o_thermal_warn_flag(o_thermal_warn_flag), .o_all_off(o_all_off), .o_cmd_word(o_cmd_word),
    .o_drive_word(o_drive_word), .o_cmd_valid(o_cmd_valid), .o_frame_error(o_frame_error)
);

// File: tfs_host.sv
module tfs_host (
    // Link pins toward the device
    output logic      o_sclk,
    output logic      o_chip_select_n,
    output logic      o_si,
    input  wire logic i_so
);
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////
    // Idle: clock parked low, nothing selected; late update so the link's clear edge is seen
    initial begin
        o_sclk          <= 1'b0;
        o_chip_select_n <= 1'b1;
        o_si            <= 1'b1;
    end

    // Frame of nbits, LSB first; odd 1.3 ns offset keeps edges off the core clock
    task automatic xfer(input int nbits, input logic [47:0] tx, output logic [47:0] rx);
        rx   = '0;
        o_si = 1'b0;
        #1.3;
        o_chip_select_n = 1'b0;
        #10;
        rx[0] = i_so;
        o_si  = tx[0];
        #10;
        for (int k = 0; k < nbits; k++) begin
            rx[k]  = i_so;
            o_sclk = 1'b1;
            #16;
            o_sclk = 1'b0;
            o_si   = (k + 1 < nbits) ? tx[k + 1] : ~tx[k];
            #16;
        end
        o_chip_select_n = 1'b1;
        #200;
    endtask : xfer

    // Clock and data wiggle while deselected
    task automatic noise();
        for (int k = 0; k < 16; k++) begin
            o_si   = k[0];
            o_sclk = 1'b1;
            #16;
            o_sclk = 1'b0;
            #16;
        end
    endtask : noise
endmodule : tfs_host

// File: tfs_top_test.sv
module tfs_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk = 1'b0;
    logic        reset;
    logic [2:0]  warn_hot, shut_hot, shut_cool;
    logic [15:1] diag;
    wire         sclk, cs_n, si, so;
    logic        warn_flag, all_off, cmd_valid, frame_error;
    logic [15:0] cmd_word, drive_word;
    logic [47:0] rx;
    int          failures, total_checks, cycles, n_cmd, n_err, exp_cmd, exp_err;

    tfs_top DUT (
        .i_core_clk(core_clk), .i_reset(reset), .i_sclk(sclk), .i_chip_select_n(cs_n),
        .i_si(si), .o_so(so), .i_warn_hot(warn_hot), .i_shut_hot(shut_hot),
        .i_shut_cool(shut_cool), .i_diag_other(diag), .o_thermal_warn_flag(warn_flag),
        .o_all_off(all_off), .o_cmd_word(cmd_word), .o_drive_word(drive_word),
        .o_cmd_valid(cmd_valid), .o_frame_error(frame_error)
    );
    tfs_host u_host (.o_sclk(sclk), .o_chip_select_n(cs_n), .o_si(si), .i_so(so));

    always #2.5 core_clk = ~core_clk;

    // Pulse counts and hang guard, far above the expected run
    always @(posedge core_clk) begin
        cycles++;
        if (cmd_valid === 1'b1) n_cmd++;
        if (frame_error === 1'b1) n_err++;
        if (cycles == 40000) begin
            failures++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    // Comparator change, then past sync and flag latency
    task automatic set_th(input logic [2:0] w, input logic [2:0] s, input logic [2:0] c);
        @(posedge core_clk);
        warn_hot  <= w;
        shut_hot  <= s;
        shut_cool <= c;
        repeat (8) @(posedge core_clk);
    endtask : set_th

    // Whole words give a command, anything else an error pulse
    task automatic frm(input int nbits, input logic [47:0] tx);
        u_host.xfer(nbits, tx, rx);
        if (nbits % 16 == 0 && nbits > 0) exp_cmd++;
        else exp_err++;
    endtask : frm

    ////////////////////////////////////////////////////////////
    initial begin
        // Non-blocking so the link's asynchronous reset sees a real edge at start
        reset     <= 1'b1;
        warn_hot  <= 3'h0;
        shut_hot  <= 3'h0;
        shut_cool <= 3'h7;
        diag      <= 15'h52E1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        check(warn_flag, 1'b0);
        check(all_off, 1'b0);
        frm(16, 48'h0002);
        check(rx[15:0], {diag, 1'b0});
        check(cmd_word, 16'h0002);
        for (int ch = 0; ch < 3; ch++) begin
            // Warning: sticky, kept while live, cleared by request
            set_th(3'h1 << ch, 3'h0, 3'h7);
            check(warn_flag, 1'b1);
            check(all_off, 1'b0);
            frm(16, 48'h0001);
            check(rx[0], 1'b1);
            check(warn_flag, 1'b1);
            set_th(3'h0, 3'h0, 3'h7);
            frm(0, 48'h0);
            check(rx[0], 1'b1);
            frm(16, 48'h0004);
            check(warn_flag, 1'b1);
            check(drive_word, 16'h0004);
            frm(16, 48'h0005);
            check(warn_flag, 1'b0);
            frm(0, 48'h0);
            check(rx[0], 1'b0);
            // Shutdown: released only cooled, with request and turn-on
            set_th(3'h0, 3'h1 << ch, 3'h0);
            check(all_off, 1'b1);
            check(drive_word, 16'h0000);
            set_th(3'h0, 3'h0, 3'h0);
            frm(16, 48'h1003);
            check(all_off, 1'b1);
            set_th(3'h0, 3'h0, 3'h7);
            frm(16, 48'h1002);
            check(all_off, 1'b1);
            frm(16, 48'h0001);
            check(all_off, 1'b1);
            frm(16, 48'h1003);
            check(all_off, 1'b0);
            check(drive_word, 16'h1002);
        end
        // Two-word chain: first word passes on, last is the command
        frm(32, 48'h1234_0ABC);
        check(rx[15:0], {diag, 1'b0});
        check(rx[31:16], 16'h0ABC);
        check(cmd_word, 16'h1234);
        check(drive_word, 16'h1234 & tfs_pkg::TURN_ON_MASK);
        // Stray length and deselected traffic change nothing
        frm(20, 48'hF_5555);
        check(cmd_word, 16'h1234);
        u_host.noise();
        repeat (20) @(posedge core_clk);
        check(cmd_word, 16'h1234);
        check(n_cmd, exp_cmd);
        check(n_err, exp_err);
        summarize();
    end
endmodule : tfs_top_test
